// File: hdl/lcr_lane_regs.sv
// Lane configuration registers for two lanes behind an AXI4-Lite slave.
`timescale 1ns/1ns
module lcr_lane_regs #(
  parameter int ADDR_W = 12,
  parameter int PERIOD_CYC = lcr_pkg::TEST_PERIOD_CYC,
  parameter int ATTEMPTS = lcr_pkg::TEST_ATTEMPTS
) (
  // Clock, reset and clock enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin straps and per-lane detection results.
  input wire logic [3:0] signal_detect_threshold_pin,
  input wire logic [1:0] receiver_presence_check_pin,
  input wire logic [1:0] detect_hit,
  // Per-lane settings, index 0 is the first lane, index 1 the second.
  output logic [1:0][2:0] output_attenuation,
  output logic [1:0][1:0] assert_threshold,
  output logic [1:0][1:0] deassert_threshold,
  output logic [1:0][7:0] equalizer,
  output logic [1:0] termination_on,
  output logic [1:0] detect_test,
  // Interrupt.
  output logic irq
);
  localparam logic [1:0][7:0] ATT_IDX = {lcr_pkg::IDX_L6_ATTEN, lcr_pkg::IDX_L5_ATTEN};
  localparam logic [1:0][7:0] THR_IDX = {lcr_pkg::IDX_L6_THRESH, lcr_pkg::IDX_L5_THRESH};
  localparam logic [1:0][7:0] DET_IDX = {lcr_pkg::IDX_L6_DETECT, lcr_pkg::IDX_L5_DETECT};
  localparam logic [1:0][7:0] EQ_IDX = {lcr_pkg::IDX_L6_EQ, lcr_pkg::IDX_L5_EQ};

  // Word index of a byte address.
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // True for every index that answers OKAY.
  function automatic logic is_mapped(input logic [7:0] i);
    return i == lcr_pkg::IDX_GLOBAL_CTRL || i == lcr_pkg::IDX_L5_DETECT ||
      i == lcr_pkg::IDX_L5_EQ || i == lcr_pkg::IDX_L5_ATTEN ||
      i == lcr_pkg::IDX_L5_THRESH || i == lcr_pkg::IDX_RSVD_LO ||
      i == lcr_pkg::IDX_RSVD_HI || i == lcr_pkg::IDX_L6_DETECT ||
      i == lcr_pkg::IDX_L6_EQ || i == lcr_pkg::IDX_L6_ATTEN ||
      i == lcr_pkg::IDX_L6_THRESH || i == lcr_pkg::IDX_IRQ_STATUS ||
      i == lcr_pkg::IDX_IRQ_MASK;
  endfunction

  // Bus bookkeeping.
  logic aw_have_r, w_have_r;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  // Register storage.
  logic [7:0] glob_r;
  logic [1:0][2:0] att_r;
  logic [1:0][3:0] thr_r;
  logic [1:0][1:0] det_r;
  logic [1:0][7:0] eq_r;
  logic [1:0][1:0] eff_mode_r;
  // Interrupt wires.
  logic [lcr_pkg::IRQ_W-1:0] irq_status, irq_mask;
  logic [1:0] found, give_up;
  logic [7:0] rd_byte;

  // Handshakes and write decode.
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [7:0] wr_idx = idx_of(awaddr_q);
  wire [7:0] rd_idx = idx_of(s_axi_araddr);
  wire wr_en = wr_go & wstrb_q;
  wire wr_glob = wr_en && wr_idx == lcr_pkg::IDX_GLOBAL_CTRL;
  wire wr_stat = wr_en && wr_idx == lcr_pkg::IDX_IRQ_STATUS;
  wire wr_mask = wr_en && wr_idx == lcr_pkg::IDX_IRQ_MASK;
  wire thr_by_reg = glob_r[lcr_pkg::GLB_THRESH_BIT];
  wire det_by_reg = glob_r[lcr_pkg::GLB_DETECT_BIT];

  // Write address and data are taken in either order and held until used.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lcr_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~(aw_hs | aw_have_r | s_axi_bvalid);
      s_axi_wready <= ~(w_hs | w_have_r | s_axi_bvalid);
      if (aw_hs) begin
        aw_have_r <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (w_hs) begin
        w_have_r <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_idx) ? lcr_pkg::RESP_OKAY : lcr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Global control holds the two register-override bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glob_r <= lcr_pkg::GLOBAL_RST;
    end else if (ce && wr_glob) begin
      glob_r <= wdata_q;
    end
  end

  // One identical register set and sequencer per lane.
  for (genvar l = 0; l < 2; l++) begin : g_lane
    wire wr_att = wr_en && wr_idx == ATT_IDX[l];
    wire wr_thr = wr_en && wr_idx == THR_IDX[l];
    wire wr_det = wr_en && wr_idx == DET_IDX[l];
    wire wr_eq = wr_en && wr_idx == EQ_IDX[l];

    // Writable fields; bit 7 of attenuation is status and never stored.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        att_r[l] <= lcr_pkg::ATTEN_RST;
        thr_r[l] <= lcr_pkg::THRESH_RST;
        det_r[l] <= lcr_pkg::DETECT_RST;
        eq_r[l] <= lcr_pkg::EQ_RST;
      end else if (ce) begin
        if (wr_att) att_r[l] <= wdata_q[2:0];
        if (wr_thr) thr_r[l] <= wdata_q[3:0];
        if (wr_det) det_r[l] <= wdata_q[lcr_pkg::MODE_LSB +: 2];
        if (wr_eq) eq_r[l] <= wdata_q;
      end
    end

    // Effective thresholds and mode pick register or pin as the override bits say; attenuation and equalizer take the register.
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        output_attenuation[l] <= lcr_pkg::ATTEN_RST;
        assert_threshold[l] <= lcr_pkg::THRESH_RST[3:2];
        deassert_threshold[l] <= lcr_pkg::THRESH_RST[1:0];
        equalizer[l] <= lcr_pkg::EQ_RST;
        eff_mode_r[l] <= lcr_pkg::DETECT_RST;
      end else if (ce) begin
        output_attenuation[l] <= att_r[l];
        assert_threshold[l] <= thr_by_reg ? thr_r[l][3:2]
          : signal_detect_threshold_pin[3:2];
        deassert_threshold[l] <= thr_by_reg ? thr_r[l][1:0]
          : signal_detect_threshold_pin[1:0];
        equalizer[l] <= eq_r[l];
        eff_mode_r[l] <= det_by_reg ? det_r[l] : receiver_presence_check_pin;
      end
    end

    lcr_detect_seq #(
      .PERIOD_CYC(PERIOD_CYC),
      .ATTEMPTS(ATTEMPTS)
    ) u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .mode(eff_mode_r[l]),
      .hit(detect_hit[l]),
      .test_o(detect_test[l]),
      .term_o(termination_on[l]),
      .found_o(found[l]),
      .give_up_o(give_up[l])
    );
  end

  // Events: bits 1:0 detection per lane, bits 3:2 search gave up per lane.
  lcr_irq #(
    .W(lcr_pkg::IRQ_W)
  ) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set({give_up, found}),
    .clr_we(wr_stat),
    .mask_we(wr_mask),
    .wbits(wdata_q[lcr_pkg::IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq)
  );

  // Read selection; unmapped and reserved indices read zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      lcr_pkg::IDX_GLOBAL_CTRL: rd_byte = glob_r;
      lcr_pkg::IDX_L5_ATTEN: rd_byte = {termination_on[0], 4'h0, att_r[0]};
      lcr_pkg::IDX_L6_ATTEN: rd_byte = {termination_on[1], 4'h0, att_r[1]};
      lcr_pkg::IDX_L5_THRESH: rd_byte = {4'h0, thr_r[0]};
      lcr_pkg::IDX_L6_THRESH: rd_byte = {4'h0, thr_r[1]};
      lcr_pkg::IDX_L5_DETECT: rd_byte = {4'h0, det_r[0], 2'h0};
      lcr_pkg::IDX_L6_DETECT: rd_byte = {4'h0, det_r[1], 2'h0};
      lcr_pkg::IDX_L5_EQ: rd_byte = eq_r[0];
      lcr_pkg::IDX_L6_EQ: rd_byte = eq_r[1];
      lcr_pkg::IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
      lcr_pkg::IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel answers on the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lcr_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~(ar_hs | s_axi_rvalid);
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= is_mapped(rd_idx) ? lcr_pkg::RESP_OKAY : lcr_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks on the register bank.
  AST_STATUS_BIT: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ar_hs && rd_idx == lcr_pkg::IDX_L5_ATTEN |=> s_axi_rdata[7] == $past(termination_on[0]))
    else $error("Attenuation bit 7 does not show termination.");
  AST_ATTEN_WRITE: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    wr_en && wr_idx == lcr_pkg::IDX_L6_ATTEN |-> ##2 output_attenuation[1] == $past(wdata_q[2:0], 2))
    else $error("Attenuation write did not reach the output.");
  AST_ATTEN_OUT: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ce |=> output_attenuation == $past(att_r))
    else $error("Attenuation output lags its register.");
  AST_THR_PIN: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ce && !thr_by_reg |=> {assert_threshold[0], deassert_threshold[0]} ==
      $past(signal_detect_threshold_pin))
    else $error("Threshold not taken from the pin.");
  AST_THR_REG: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ce && thr_by_reg |=> {assert_threshold[1], deassert_threshold[1]} == $past(thr_r[1]))
    else $error("Threshold not taken from the register.");
  AST_MODE_SEL: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ce |=> eff_mode_r[0] == $past(det_by_reg ? det_r[0] : receiver_presence_check_pin))
    else $error("Presence check mode has the wrong source.");
  AST_EQ_RESET: assert property (@(posedge aclk)
    !aresetn |=> eq_r == {2{lcr_pkg::EQ_RST}})
    else $error("Equalizer did not reset to its default.");
  AST_LANE_APART: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    wr_en && wr_idx == lcr_pkg::IDX_L5_EQ |=> $stable(eq_r[1]))
    else $error("First lane write changed the second lane.");
  COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) wr_go);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) ar_hs);
  COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule

// File: common/lcr_pkg.sv
// Shared constants and types of the lane configuration register bank.
package lcr_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h08;
  localparam logic [7:0] IDX_L5_DETECT = 8'h32;
  localparam logic [7:0] IDX_L5_EQ = 8'h33;
  localparam logic [7:0] IDX_L5_ATTEN = 8'h35;
  localparam logic [7:0] IDX_L5_THRESH = 8'h36;
  localparam logic [7:0] IDX_RSVD_LO = 8'h37;
  localparam logic [7:0] IDX_RSVD_HI = 8'h38;
  localparam logic [7:0] IDX_L6_DETECT = 8'h39;
  localparam logic [7:0] IDX_L6_EQ = 8'h3a;
  localparam logic [7:0] IDX_L6_ATTEN = 8'h3c;
  localparam logic [7:0] IDX_L6_THRESH = 8'h3d;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  // Field positions.
  localparam int GLB_THRESH_BIT = 6;
  localparam int GLB_DETECT_BIT = 3;
  localparam int TERM_STATUS_BIT = 7;
  localparam int MODE_LSB = 2;
  // Values after reset.
  localparam logic [2:0] ATTEN_RST = 3'h2;
  localparam logic [3:0] THRESH_RST = 4'h0;
  localparam logic [1:0] DETECT_RST = 2'h0;
  localparam logic [7:0] EQ_RST = 8'h2f;
  localparam logic [7:0] GLOBAL_RST = 8'h00;
  // Receiver presence check modes.
  typedef enum logic [1:0] {
    MODE_HIZ = 2'h0,
    MODE_AUTO_ONCE = 2'h1,
    MODE_AUTO_EVER = 2'h2,
    MODE_TERM = 2'h3
  } lcr_mode_e;
  // Sequencer states, Gray coded along idle, search, found.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEARCH = 2'h1,
    ST_FOUND = 2'h3,
    ST_GAVE_UP = 2'h2
  } lcr_state_e;
  // Timing of the presence check at a 125 MHz clock.
  localparam int CLK_KHZ = 125000;
  localparam int TEST_PERIOD_MS = 12;
  localparam int SEARCH_SPAN_MS = 600;
  localparam int TEST_PERIOD_CYC = TEST_PERIOD_MS * CLK_KHZ;
  localparam int TEST_ATTEMPTS = SEARCH_SPAN_MS / TEST_PERIOD_MS;
  // Bus responses and interrupt layout.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int IRQ_W = 4;
endpackage

// File: hdl/lcr_detect_seq.sv
// Per-lane receiver presence check sequencer and termination control.
`timescale 1ns/1ns
module lcr_detect_seq #(
  parameter int PERIOD_CYC = lcr_pkg::TEST_PERIOD_CYC,
  parameter int ATTEMPTS = lcr_pkg::TEST_ATTEMPTS
) (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Effective mode and result of the analog test.
  input wire logic [1:0] mode,
  input wire logic hit,
  // Test strobe, termination and one-cycle events.
  output logic test_o,
  output logic term_o,
  output logic found_o,
  output logic give_up_o
);
  localparam int CW = $clog2(PERIOD_CYC + 1);
  localparam int AW = $clog2(ATTEMPTS + 1);
  localparam logic [CW-1:0] RELOAD = CW'(PERIOD_CYC - 1);
  localparam logic [AW-1:0] LAST = AW'(ATTEMPTS);

  lcr_pkg::lcr_state_e st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [AW-1:0] tries_r, tries_nxt;
  logic [1:0] mode_r;
  logic test_nxt, found_nxt, give_nxt, term_nxt;

  // A change of mode restarts the sequence from idle.
  wire mode_chg = mode != mode_r;
  wire is_auto = mode == lcr_pkg::MODE_AUTO_ONCE || mode == lcr_pkg::MODE_AUTO_EVER;
  wire is_once = mode == lcr_pkg::MODE_AUTO_ONCE;
  wire tick = cnt_r == '0;

  // Next state: test on each period expiry, stop on a hit or, in auto-once mode, after the last try.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    tries_nxt = tries_r;
    test_nxt = 1'b0;
    found_nxt = 1'b0;
    give_nxt = 1'b0;
    if (mode_chg) begin
      st_nxt = lcr_pkg::ST_IDLE;
    end else begin
      unique case (st_r)
        lcr_pkg::ST_IDLE: begin
          if (is_auto) begin
            st_nxt = lcr_pkg::ST_SEARCH;
            cnt_nxt = '0;
            tries_nxt = '0;
          end
        end
        lcr_pkg::ST_SEARCH: begin
          if (hit) begin
            st_nxt = lcr_pkg::ST_FOUND;
            found_nxt = 1'b1;
          end else if (tick && is_once && tries_r == LAST) begin
            st_nxt = lcr_pkg::ST_GAVE_UP;
            give_nxt = 1'b1;
          end else if (tick) begin
            test_nxt = 1'b1;
            cnt_nxt = RELOAD;
            tries_nxt = (tries_r == LAST) ? tries_r : tries_r + 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        lcr_pkg::ST_FOUND, lcr_pkg::ST_GAVE_UP: begin
          st_nxt = st_r;
        end
      endcase
    end
    // Fixed modes force the termination off (Hi-Z mode) or on (term mode); auto modes stay Hi-Z until found.
    term_nxt = (mode == lcr_pkg::MODE_TERM) || (is_auto && st_nxt == lcr_pkg::ST_FOUND);
  end

  // State and output flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= lcr_pkg::ST_IDLE;
      cnt_r <= '0;
      tries_r <= '0;
      mode_r <= lcr_pkg::DETECT_RST;
      test_o <= 1'b0;
      term_o <= 1'b0;
      found_o <= 1'b0;
      give_up_o <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      tries_r <= tries_nxt;
      mode_r <= mode;
      test_o <= test_nxt;
      term_o <= term_nxt;
      found_o <= found_nxt;
      give_up_o <= give_nxt;
    end
  end

  // Checks on the sequencer.
  AST_FIXED_TERM: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    ce && mode[1] == mode[0] |=> term_o == $past(mode[0]))
    else $error("Fixed mode did not set the termination.");
  AST_GIVE_UP_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
    give_up_o |-> tries_r == LAST && mode_r == lcr_pkg::MODE_AUTO_ONCE)
    else $error("Search stopped before the last attempt.");
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    test_o |-> cnt_r == RELOAD && st_r == lcr_pkg::ST_SEARCH)
    else $error("Test issued without a full period reload.");
  AST_HIZ_SEARCH: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == lcr_pkg::ST_SEARCH |-> !term_o)
    else $error("Termination applied before detection.");
  COV_FOUND: cover property (@(posedge aclk) disable iff (!aresetn) found_o);
  COV_GIVE_UP: cover property (@(posedge aclk) disable iff (!aresetn) give_up_o);
endmodule

// File: hdl/lcr_irq.sv
// Sticky event status with mask and one level interrupt.
`timescale 1ns/1ns
module lcr_irq #(
  parameter int W = lcr_pkg::IRQ_W
) (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Hardware events and software writes.
  input wire logic [W-1:0] set,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [W-1:0] wbits,
  // Status, mask and interrupt.
  output logic [W-1:0] status_o,
  output logic [W-1:0] mask_o,
  output logic irq_o
);
  logic [W-1:0] status_nxt, mask_nxt;

  // A set in the cycle of a write-one clear survives the clear.
  assign status_nxt = (status_o & ~(clr_we ? wbits : '0)) | set;
  assign mask_nxt = mask_we ? wbits : mask_o;

  // Registered status, mask and interrupt level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_o <= '0;
      mask_o <= '0;
      irq_o <= 1'b0;
    end else if (ce) begin
      status_o <= status_nxt;
      mask_o <= mask_nxt;
      irq_o <= |(status_nxt & mask_nxt);
    end
  end
endmodule

// File: dv/lcr_lane_regs_bench.sv
// Self-checking bench for the lane configuration register bank.
`timescale 1ns/1ns
module lcr_lane_regs_bench;
  // Short detection timing so the auto-detect sequences finish quickly.
  localparam int PER = 20;
  localparam int ATT = 3;
  // Clock, reset and bus signals.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, term, test;
  logic [3:0] th_pin = 4'h9;
  logic [1:0] rx_pin = 2'h3;
  logic [1:0] hit = 2'h0;
  logic ce = 1'b1;
  logic [1:0][2:0] atten;
  logic [1:0][1:0] ath, dth;
  logic [1:0][7:0] eq;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n0, n1, gap;

  // Design under test with shortened detection timing.
  lcr_lane_regs #(.ADDR_W(12), .PERIOD_CYC(PER), .ATTEMPTS(ATT)) lcr_lane_regs_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .signal_detect_threshold_pin(th_pin), .receiver_presence_check_pin(rx_pin),
    .detect_hit(hit), .output_attenuation(atten), .assert_threshold(ath),
    .deassert_threshold(dth), .equalizer(eq), .termination_on(term),
    .detect_test(test), .irq(irq)
  );

  // Free-running 125 MHz clock.
  initial begin
    forever #4 aclk = ~aclk;
  end

  // Cycle ceiling that cuts a hung run short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Writes one register by index; address and data are released as each is taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge aclk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", 32'(lcr_pkg::RESP_OKAY), 32'(bresp));
  endtask

  // Reads one register by index and compares data and response.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    @(posedge aclk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read data", {24'h0, exp}, rdata);
    check("read response", 32'(resp), 32'(rresp));
  endtask

  // Counts test pulses per lane and the spacing of the first lane's pulses.
  task automatic count_tests(input int cycles);
    int last;
    n0 = 0;
    n1 = 0;
    gap = 0;
    last = -1;
    for (int i = 0; i < cycles; i++) begin
      @(posedge aclk);
      if (test[0] === 1'b1) begin
        if (last >= 0) gap = i - last;
        last = i;
        n0++;
      end
      if (test[1] === 1'b1) n1++;
    end
  endtask

  // Main sequence: reset, register map, overrides, detection and interrupt.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check("atten lane0", 32'h2, 32'(atten[0]));
    check("eq lane1", 32'h2f, 32'(eq[1]));
    check("assert thr from pin", 32'h2, 32'(ath[0]));
    check("term from pin mode", 32'h3, 32'(term));
    rchk(8'h35, 8'h82, lcr_pkg::RESP_OKAY);
    rchk(8'h36, 8'h00, lcr_pkg::RESP_OKAY);
    rchk(8'h3a, 8'h2f, lcr_pkg::RESP_OKAY);
    rchk(8'h39, 8'h00, lcr_pkg::RESP_OKAY);
    rchk(8'h37, 8'h00, lcr_pkg::RESP_OKAY);
    rchk(8'h50, 8'h00, lcr_pkg::RESP_SLVERR);
    rx_pin <= 2'h0;
    // Every attenuation code on the second lane, with the status bit written high.
    for (int c = 0; c < 8; c++) begin
      wr(8'h3c, 8'h80 | 8'(c));
      // The output follows the register one edge after the write response.
      @(posedge aclk);
      check("atten lane1", 32'(c), 32'(atten[1]));
      rchk(8'h3c, 8'(c), lcr_pkg::RESP_OKAY);
    end
    check("atten lane0 kept", 32'h2, 32'(atten[0]));
    wr(8'h36, 8'h0d);
    check("assert thr pin kept", 32'h2, 32'(ath[0]));
    wr(8'h08, 8'h40);
    repeat (2) @(posedge aclk);
    check("assert thr reg", 32'h3, 32'(ath[0]));
    check("deassert thr reg", 32'h1, 32'(dth[0]));
    check("lane1 thr default", 32'h0, 32'({ath[1], dth[1]}));
    wr(8'h08, 8'h48);
    wr(8'h32, 8'h0c);
    repeat (4) @(posedge aclk);
    check("term forced", 32'h1, 32'(term));
    wr(8'h71, 8'h0f);
    wr(8'h32, 8'h08);
    wr(8'h39, 8'h04);
    count_tests(200);
    check("tests lane1", 32'(ATT), 32'(n1));
    check("tests lane0 go on", 32'h1, 32'(n0 > ATT));
    check("test spacing", 32'(PER), 32'(gap));
    check("term during search", 32'h0, 32'(term));
    check("irq gave up", 32'h1, 32'(irq));
    rchk(8'h70, 8'h08, lcr_pkg::RESP_OKAY);
    // A detection that arrives while the clock enable is low waits until it returns.
    ce <= 1'b0;
    hit <= 2'h1;
    repeat (4) @(posedge aclk);
    check("term frozen", 32'h0, 32'(term));
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    check("term found", 32'h1, 32'(term));
    rchk(8'h35, 8'h82, lcr_pkg::RESP_OKAY);
    rchk(8'h70, 8'h09, lcr_pkg::RESP_OKAY);
    count_tests(60);
    check("tests after found", 32'h0, 32'(n0 + n1));
    wr(8'h71, 8'h00);
    check("irq masked", 32'h0, 32'(irq));
    wr(8'h71, 8'h0f);
    check("irq unmasked", 32'h1, 32'(irq));
    wr(8'h70, 8'h09);
    rchk(8'h70, 8'h00, lcr_pkg::RESP_OKAY);
    check("irq cleared", 32'h0, 32'(irq));
    stop_test();
  end
endmodule
